// *** include/cies_defs.vh ***
// Constants for the instruction execution subset core
`ifndef CIES_DEFS_VH
`define CIES_DEFS_VH

// ----------------------------------------
// Instruction cycle divider
// ----------------------------------------
`define CIES_CYC_DIV 2'h3
// ----------------------------------------
// Opcode encodings
// ----------------------------------------
`define CIES_OP_SKIP_SET 4'h7
`define CIES_OP_CALL 4'h9
`define CIES_OP_COMPL 6'h09
`define CIES_OP_CLR_REG 7'h03
`define CIES_OP_CLR_ACC 12'h040
`define CIES_OP_WD_CLR 12'h004
// ----------------------------------------
// Status register
// ----------------------------------------
`define CIES_STATUS_ADDR 5'h03
`define CIES_STATUS_RST 8'h18
`define CIES_ST_ZERO 2
`define CIES_ST_POWERDOWN 3
`define CIES_ST_TIMEOUT 4
// ----------------------------------------
// Reset values and watchdog
// ----------------------------------------
`define CIES_PC_RST 11'h000
`define CIES_WD_PRE_TOP 8'hff
`define CIES_WD_CNT_TOP 8'hff

`endif

// *** hw/cies_file_regs.v ***
// File register array of the execution core
`timescale 1ns/100ps
module cies_file_regs (
  input wire clk_sys_in,      // System clock
  input wire [4:0] addr_in,   // Register address
  input wire we_in,           // Write strobe
  input wire [7:0] wdata_in,  // Write data
  output wire [7:0] rdata_out // Read data
);
  reg [7:0] mem_r [0:31];

  assign rdata_out = mem_r[addr_in];

  always @(posedge clk_sys_in)
  begin
    if (we_in)
    begin
      mem_r[addr_in] <= wdata_in;
    end
  end
endmodule

// *** hw/cies_watchdog.v ***
// Watchdog counter with shared prescaler
`timescale 1ns/100ps
`include "cies_defs.vh"
module cies_watchdog (
  input wire clk_sys_in,      // System clock
  input wire rstn_in,         // Async reset, low
  input wire tick_in,         // Instruction cycle enable
  input wire clear_in,        // Watchdog clear pulse
  input wire psa_in,          // Prescaler on watchdog
  output wire [7:0] count_out, // Counter value
  output wire expire_out      // Overflow pulse
);
  reg [7:0] pre_r;
  reg [7:0] cnt_r;
  reg expire_r;
  wire step;

  assign step = ~psa_in | (pre_r == `CIES_WD_PRE_TOP);
  assign count_out = cnt_r;
  assign expire_out = expire_r;

  always @(posedge clk_sys_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      pre_r <= 8'h00;
      cnt_r <= 8'h00;
      expire_r <= 1'b0;
    end
    else
    begin
      expire_r <= 1'b0;
      if (clear_in)
      begin
        cnt_r <= 8'h00;
        if (psa_in)
        begin
          pre_r <= 8'h00;
        end
      end
      else if (tick_in)
      begin
        if (psa_in)
        begin
          pre_r <= pre_r + 8'h01;
        end
        if (step)
        begin
          cnt_r <= cnt_r + 8'h01;
          expire_r <= (cnt_r == `CIES_WD_CNT_TOP);
        end
      end
    end
  end
endmodule

// *** hw/cies_core.v ***
// Execution core for a subset of the 8-bit instruction set
`timescale 1ns/100ps
`include "cies_defs.vh"
module cies_core (
  input wire clk_sys_in,          // System clock, 200 MHz
  input wire rstn_in,             // Async reset, low
  input wire [11:0] instr_in,     // Word at pc_out
  input wire psa_in,              // Prescaler on watchdog
  output wire [10:0] pc_out,      // Fetch address
  output wire [7:0] w_out,        // Accumulator
  output wire [7:0] status_out,   // Status register
  output wire [10:0] stack_top_out, // Stack top
  output wire [7:0] wdt_count_out, // Watchdog counter
  output wire wdt_expire_out,     // Watchdog overflow pulse
  output wire cyc_en_out,         // Instruction cycle enable
  output wire skip_slot_out       // Discarded slot in execution
);

  // ----------------------------------------
  // Functions
  // ----------------------------------------
  function is_zero;
    input [7:0] val;
    begin
      is_zero = (val == 8'h00);
    end
  endfunction

  function [7:0] with_zero;
    input [7:0] st;
    input [7:0] res;
    begin
      with_zero = st;
      with_zero[`CIES_ST_ZERO] = is_zero(res);
    end
  endfunction

  // Only the page and upper bits of status take a data write
  function [7:0] status_wr;
    input [7:0] st;
    input [7:0] val;
    begin
      status_wr = st;
      status_wr[7:5] = val[7:5];
    end
  endfunction

  function [7:0] read_operand;
    input [4:0] addr;
    input [7:0] st;
    input [7:0] arr;
    begin
      if (addr == `CIES_STATUS_ADDR)
      begin
        read_operand = st;
      end
      else
      begin
        read_operand = arr;
      end
    end
  endfunction

  function bit_of;
    input [7:0] val;
    input [2:0] idx;
    begin
      bit_of = val[idx];
    end
  endfunction

  function [10:0] call_target;
    input [1:0] page;
    input [7:0] k;
    begin
      call_target = {page, 1'b0, k};
    end
  endfunction

  // ----------------------------------------
  // State
  // ----------------------------------------
  reg [1:0] div_r;
  reg cyc_en_r;
  reg [10:0] pc_r;
  reg [10:0] pc_nxt;
  reg [11:0] ir_r;
  reg [11:0] ir_nxt;
  reg flush_r;
  reg flush_nxt;
  reg [7:0] w_r;
  reg [7:0] w_nxt;
  reg [7:0] status_r;
  reg [7:0] status_nxt;
  reg [10:0] stk0_r;
  reg [10:0] stk1_r;
  reg push;
  reg fr_we;
  reg [7:0] fr_wdata;
  reg wd_clear;
  wire [7:0] fr_rdata;
  wire [7:0] src;
  wire [4:0] faddr;
  wire is_status;
  wire wd_expire;

  // ----------------------------------------
  // Decode
  // ----------------------------------------
  wire dec_skip_set;
  wire dec_call;
  wire dec_compl;
  wire dec_clr_reg;
  wire dec_clr_acc;
  wire dec_wd_clr;

  assign dec_skip_set = (ir_r[11:8] == `CIES_OP_SKIP_SET);
  assign dec_call = (ir_r[11:8] == `CIES_OP_CALL);
  assign dec_compl = (ir_r[11:6] == `CIES_OP_COMPL);
  assign dec_clr_reg = (ir_r[11:5] == `CIES_OP_CLR_REG);
  assign dec_clr_acc = (ir_r == `CIES_OP_CLR_ACC);
  assign dec_wd_clr = (ir_r == `CIES_OP_WD_CLR);

  assign faddr = ir_r[4:0];
  assign is_status = (faddr == `CIES_STATUS_ADDR);
  assign src = read_operand(faddr, status_r, fr_rdata);

  // ----------------------------------------
  // Submodules
  // ----------------------------------------
  cies_file_regs u_regs (
    .clk_sys_in(clk_sys_in),
    .addr_in(faddr),
    .we_in(fr_we),
    .wdata_in(fr_wdata),
    .rdata_out(fr_rdata)
  );

  cies_watchdog u_wd (
    .clk_sys_in(clk_sys_in),
    .rstn_in(rstn_in),
    .tick_in(cyc_en_r),
    .clear_in(wd_clear),
    .psa_in(psa_in),
    .count_out(wdt_count_out),
    .expire_out(wd_expire)
  );

  assign wdt_expire_out = wd_expire;
  assign pc_out = pc_r;
  assign w_out = w_r;
  assign status_out = status_r;
  assign stack_top_out = stk0_r;
  assign cyc_en_out = cyc_en_r;
  assign skip_slot_out = flush_r;

  // ----------------------------------------
  // Instruction cycle divider
  // ----------------------------------------
  always @(posedge clk_sys_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      div_r <= 2'h0;
      cyc_en_r <= 1'b0;
    end
    else
    begin
      cyc_en_r <= (div_r == `CIES_CYC_DIV);
      div_r <= div_r + 2'h1;
    end
  end

  // ----------------------------------------
  // Execute
  // ----------------------------------------
  always @*
  begin
    pc_nxt = pc_r;
    ir_nxt = ir_r;
    flush_nxt = flush_r;
    w_nxt = w_r;
    status_nxt = status_r;
    push = 1'b0;
    fr_we = 1'b0;
    fr_wdata = 8'h00;
    wd_clear = 1'b0;
    if (wd_expire)
    begin
      status_nxt[`CIES_ST_TIMEOUT] = 1'b0;
    end
    if (cyc_en_r)
    begin
      ir_nxt = instr_in;
      pc_nxt = pc_r + 11'h001;
      flush_nxt = 1'b0;
      if (flush_r)
      begin
        w_nxt = w_r;
      end
      else if (dec_skip_set)
      begin
        flush_nxt = bit_of(src, ir_r[7:5]);
      end
      else if (dec_call)
      begin
        push = 1'b1;
        pc_nxt = call_target(status_r[6:5], ir_r[7:0]);
        flush_nxt = 1'b1;
      end
      else if (dec_clr_acc)
      begin
        w_nxt = 8'h00;
        status_nxt = with_zero(status_nxt, 8'h00);
      end
      else if (dec_clr_reg)
      begin
        fr_we = ~is_status;
        fr_wdata = 8'h00;
        if (is_status)
        begin
          status_nxt = status_wr(status_nxt, 8'h00);
        end
        status_nxt = with_zero(status_nxt, 8'h00);
      end
      else if (dec_compl)
      begin
        if (ir_r[5])
        begin
          fr_we = ~is_status;
          fr_wdata = ~src;
          if (is_status)
          begin
            status_nxt = status_wr(status_nxt, ~src);
          end
        end
        else
        begin
          w_nxt = ~src;
        end
        status_nxt = with_zero(status_nxt, ~src);
      end
      else if (dec_wd_clr)
      begin
        wd_clear = 1'b1;
        status_nxt[`CIES_ST_TIMEOUT] = 1'b1;
        status_nxt[`CIES_ST_POWERDOWN] = 1'b1;
      end
    end
  end

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  always @(posedge clk_sys_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      pc_r <= `CIES_PC_RST;
      ir_r <= 12'h000;
      flush_r <= 1'b1;
      w_r <= 8'h00;
      status_r <= `CIES_STATUS_RST;
    end
    else
    begin
      pc_r <= pc_nxt;
      ir_r <= ir_nxt;
      flush_r <= flush_nxt;
      w_r <= w_nxt;
      status_r <= status_nxt;
    end
  end

  // ----------------------------------------
  // Return stack
  // ----------------------------------------
  always @(posedge clk_sys_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      stk0_r <= 11'h000;
      stk1_r <= 11'h000;
    end
    else if (push)
    begin
      stk1_r <= stk0_r;
      stk0_r <= pc_r;
    end
  end
endmodule

// *** tb/cies_core_sva.sv ***
// Assertion checker for the execution core
`timescale 1ns/100ps
`include "cies_defs.vh"
module cies_core_sva (
  input wire clk_sys_in, // Clock
  input wire rstn_in, // Reset, low
  input wire [11:0] instr_in, // Fetched word
  input wire psa_in, // Prescaler select
  input wire [10:0] pc_out, // Fetch address
  input wire [7:0] w_out, // Accumulator
  input wire [7:0] status_out, // Status
  input wire [10:0] stack_top_out, // Stack top
  input wire [7:0] wdt_count_out, // Watchdog count
  input wire wdt_expire_out, // Overflow pulse
  input wire cyc_en_out, // Cycle enable
  input wire skip_slot_out // Discarded slot
);
  // ----------------------------------------
  // Executing word tracker
  // ----------------------------------------
  reg [11:0] ex_r;
  wire go = cyc_en_out && !skip_slot_out;
  wire is_call = go && ex_r[11:8] == `CIES_OP_CALL;
  wire is_skip = go && ex_r[11:8] == `CIES_OP_SKIP_SET;
  wire is_complement_register_op = go && ex_r[11:6] == `CIES_OP_COMPL;
  wire is_wdc = go && ex_r == `CIES_OP_WD_CLR;
  always @(posedge clk_sys_in or negedge rstn_in)
    if (!rstn_in)
      ex_r <= 12'h000;
    else if (cyc_en_out)
      ex_r <= instr_in;
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (!rstn_in);
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  a_cycle_gap: assert property (cyc_en_out |=> !cyc_en_out [*3] ##1 cyc_en_out)
    else $error("cycle spacing wrong");
  a_hold_results: assert property (!cyc_en_out |=> $stable(w_out) && $stable(pc_out)
    && $stable(stack_top_out)) else $error("result moved off cycle");
  a_call_dest: assert property (is_call |=> skip_slot_out &&
    pc_out == {$past(status_out[6:5]), 1'b0, $past(ex_r[7:0])}) else $error("bad call");
  a_call_push: assert property (is_call |=> stack_top_out == $past(pc_out)
    && $stable(status_out)) else $error("bad push");
  a_clr_acc: assert property (go && ex_r == `CIES_OP_CLR_ACC |=> w_out == 8'h00
    && status_out[2] && status_out[4:3] == $past(status_out[4:3])) else $error("bad clear");
  a_wd_clear: assert property (is_wdc |=> status_out[4:3] == 2'b11
    ##1 wdt_count_out == 8'h00) else $error("bad watchdog clear");
  a_complement_register_op_zero: assert property (is_complement_register_op && !ex_r[5] |=>
    status_out[2] == (w_out == 8'h00)) else $error("bad zero flag");
  a_complement_register_op_keep: assert property (is_complement_register_op && ex_r[5] |=> $stable(w_out))
    else $error("accumulator written");
  a_clr_reg_z: assert property (go && ex_r[11:5] == `CIES_OP_CLR_REG |=> status_out[2])
    else $error("zero flag not set");
  a_no_skip: assert property (go && !is_call && !is_skip |=> !skip_slot_out)
    else $error("spurious skip");
  a_expire_once: assert property (wdt_expire_out |=> !wdt_expire_out)
    else $error("long overflow pulse");
  cover property (is_call);
  cover property (is_skip ##1 skip_slot_out);
  cover property (is_wdc);
  cover property (wdt_expire_out);
endmodule
bind cies_core cies_core_sva cies_core_sva_i (.clk_sys_in, .rstn_in, .instr_in, .psa_in,
  .pc_out, .w_out, .status_out, .stack_top_out, .wdt_count_out, .wdt_expire_out,
  .cyc_en_out, .skip_slot_out);

// *** tb/cies_core_tb_top.sv ***
// Self-checking bench for the execution core
`timescale 1ns/100ps
`include "cies_defs.vh"
module cies_core_tb_top;
  reg clk_sys_in = 1'b0;
  reg rstn_in = 1'b0;
  reg [11:0] instr_in = 12'h000;
  reg psa_in = 1'b1;
  wire [10:0] pc_out;
  wire [10:0] stack_top_out;
  wire [7:0] w_out;
  wire [7:0] status_out;
  wire [7:0] wdt_count_out;
  wire wdt_expire_out;
  wire cyc_en_out;
  wire skip_slot_out;
  integer num_errors = 0;
  integer checks = 0;
  integer i;
  reg [4:0] f;
  reg [2:0] b;
  reg [7:0] k;
  reg [10:0] a;
  reg [10:0] ret;
  reg [31:0] rnd;
  cies_core cies_core_i (.clk_sys_in(clk_sys_in), .rstn_in(rstn_in), .instr_in(instr_in),
    .psa_in(psa_in), .pc_out(pc_out), .w_out(w_out), .status_out(status_out),
    .stack_top_out(stack_top_out), .wdt_count_out(wdt_count_out),
    .wdt_expire_out(wdt_expire_out), .cyc_en_out(cyc_en_out), .skip_slot_out(skip_slot_out));
  initial
  begin
    forever #2.5 clk_sys_in = ~clk_sys_in;
  end
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task report_and_stop;
  begin
    $display("errors %0d checks %0d", num_errors, checks);
    if (num_errors == 0 && checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  end
  endtask
  task chk(input [10:0] got, input [10:0] exp);
  begin
    checks = checks + 1;
    if (got !== exp)
    begin
      num_errors = num_errors + 1;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  end
  endtask
  // Present a word in the fetch slot of the next cycle
  task issue(input [11:0] word);
    integer n;
  begin
    n = 0;
    while (cyc_en_out !== 1'b1 && n < 8)
    begin
      @(negedge clk_sys_in);
      n = n + 1;
    end
    if (n == 8)
    begin
      num_errors = num_errors + 1;
      report_and_stop;
    end
    a = pc_out;
    instr_in = word;
    @(negedge clk_sys_in);
  end
  endtask
  function [10:0] call_dest(input [1:0] pg, input [7:0] kk);
    call_dest = {pg, 1'b0, kk};
  endfunction
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial
  begin
    i = $urandom(32'h6ff7e4e6);
    repeat (6) @(posedge clk_sys_in);
    @(negedge clk_sys_in);
    rstn_in = 1'b1;
    for (i = 0; i < 12; i = i + 1)
    begin
      rnd = $urandom;
      f = 5'h08 + rnd[4:0] % 5'd24;
      b = rnd[7:5];
      k = (i == 0) ? 8'hff : rnd[15:8];
      issue({`CIES_OP_CLR_REG, f});
      issue({`CIES_OP_COMPL, 1'b0, f});
      issue(12'h000);
      chk(w_out, 8'hff);
      chk(status_out[2], 1'b0);
      issue(`CIES_OP_CLR_ACC);
      issue(12'h000);
      chk({w_out, status_out[2]}, 9'h001);
      issue({`CIES_OP_COMPL, 1'b1, f});
      issue({`CIES_OP_COMPL, 1'b0, f});
      chk({w_out, status_out[2]}, 9'h000);
      issue({`CIES_OP_SKIP_SET, b, f});
      issue({`CIES_OP_COMPL, 1'b1, f});
      chk(skip_slot_out, 1'b1);
      issue({`CIES_OP_COMPL, 1'b0, f});
      issue(12'h000);
      chk({w_out, status_out[2]}, 9'h001);
      issue({`CIES_OP_CLR_REG, f});
      issue({`CIES_OP_SKIP_SET, b, f});
      issue({`CIES_OP_COMPL, 1'b1, f});
      chk(skip_slot_out, 1'b0);
      issue({`CIES_OP_COMPL, 1'b0, f});
      issue(12'h000);
      chk(w_out, 8'h00);
      // Odd rounds raise the page bits before the call, then clear them
      if (i[0])
        issue({`CIES_OP_COMPL, 1'b1, 5'h03});
      issue({`CIES_OP_CALL, k});
      ret = a + 11'h001;
      issue(12'h000);
      chk(pc_out, call_dest({2{i[0]}}, k));
      chk(stack_top_out, ret);
      chk(skip_slot_out, 1'b1);
      if (i[0])
        issue({`CIES_OP_CLR_REG, 5'h03});
    end
    // Let the watchdog run out, then clear it
    psa_in = 1'b0;
    i = 0;
    while (wdt_expire_out !== 1'b1 && i < 2000)
    begin
      @(negedge clk_sys_in);
      i = i + 1;
    end
    if (i == 2000)
    begin
      num_errors = num_errors + 1;
      report_and_stop;
    end
    @(negedge clk_sys_in);
    chk(status_out[4], 1'b0);
    issue(`CIES_OP_WD_CLR);
    issue(12'h000);
    chk(status_out[4:3], 2'b11);
    @(negedge clk_sys_in);
    chk(wdt_count_out, 8'h00);
    // Prescaler on the watchdog is cleared too: a full 256 cycles of 4 clocks follow
    psa_in = 1'b1;
    issue(`CIES_OP_WD_CLR);
    issue(12'h000);
    i = 0;
    while (wdt_count_out == 8'h00 && i < 1100)
    begin
      @(negedge clk_sys_in);
      i = i + 1;
    end
    chk(i[10:0], 11'h400);
    report_and_stop;
  end
endmodule
